// file: design/sfpm_map.sv
// Routes status flags to the open-drain alarm and clip pins.
`timescale 1ns/10ps
`include "sfpm_params.svh"
module sfpm_map (
  // Clock and synchronised reset.
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Link to the register core.
  sfpm_map_if.mapper m
);
  sfpm_pkg::sfpm_map_t q_ff, nxt_q;

  // All flags arrive active low; invert once here for readability.
  always_comb begin
    logic warn;
    logic shut;
    logic fault;
    logic [3:0] clip;
    logic cl0;
    logic cl1;
    logic second_out;
    cl0 = 1'b0;
    cl1 = 1'b0;
    warn = ~m.condition[`SFPM_CD_WARN];
    shut = ~m.condition[`SFPM_CD_SHUT];
    fault = ~m.condition[`SFPM_CD_HIGH] | ~m.condition[`SFPM_CD_LOW] |
            ~m.condition[`SFPM_CD_OC];
    clip = ~m.clip_n;
    nxt_q = q_ff;
    // Warning only reaches the pin when shutdown routing is also on.
    nxt_q.alarm_oe_n = ~((m.routing[`SFPM_RT_FAULT] & fault) |
                         (m.routing[`SFPM_RT_SHUT] & shut) |
                         (m.routing[`SFPM_RT_SHUT] &
                          m.routing[`SFPM_RT_WARN] & warn));
    // Clip split chooses one summary pin or two halves.
    if (m.routing[`SFPM_RT_SPLIT]) begin
      cl0 = |clip[1:0];
      cl1 = |clip[3:2];
    end else begin
      cl0 = |clip;
      cl1 = 1'b0;
    end
    // Load indicators join the clip pins while their routing is on.
    if (m.routing[`SFPM_RT_LOAD]) begin
      cl0 = cl0 | (|m.load[1:0]);
      cl1 = cl1 | (|m.load[3:2]);
    end
    second_out = m.routing[`SFPM_RT_SPLIT] | m.routing[`SFPM_RT_LOAD];
    nxt_q.cl0_oe_n = ~cl0;
    nxt_q.cl1_oe_n = ~(cl1 & second_out);
    // A driven shared pin would read back as its own pull, so mute is off.
    nxt_q.mute_req = ~second_out & ~m.mute_pin;
  end

  // Pins released and mute off while in reset.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_ff <= '{alarm_oe_n: 1'b1, cl0_oe_n: 1'b1, cl1_oe_n: 1'b1,
                mute_req: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign m.alarm_oe_n = q_ff.alarm_oe_n;
  assign m.cl0_oe_n = q_ff.cl0_oe_n;
  assign m.cl1_oe_n = q_ff.cl1_oe_n;
  assign m.mute_req = q_ff.mute_req;
endmodule

// file: design/sfpm_map_if.sv
// Carrier between the register core and the indicator pin mapper.
`timescale 1ns/10ps
interface sfpm_map_if;
  logic [7:0] routing;
  logic [7:0] condition;
  logic [3:0] clip_n;
  logic [3:0] load;
  logic mute_pin;
  logic alarm_oe_n;
  logic cl0_oe_n;
  logic cl1_oe_n;
  logic mute_req;

  modport core (
    output routing, condition, clip_n, load, mute_pin,
    input alarm_oe_n, cl0_oe_n, cl1_oe_n, mute_req
  );
  modport mapper (
    input routing, condition, clip_n, load, mute_pin,
    output alarm_oe_n, cl0_oe_n, cl1_oe_n, mute_req
  );
endinterface

// file: design/sfpm_params.svh
// Constants for the status, fault-pin mapping and trim register block.
`ifndef SFPM_PARAMS_SVH
`define SFPM_PARAMS_SVH

// Two-wire bus slave address and register pointer values.
`define SFPM_DEV_ADDR 7'h6c
`define SFPM_OFS_ROUTING 8'h00
`define SFPM_OFS_CONDITION 8'h01
`define SFPM_READ_UNMAPPED 8'h00

// Routing register reset value and field positions.
`define SFPM_ROUTING_POR 8'h40
`define SFPM_RT_FAULT 0
`define SFPM_RT_SHUT 1
`define SFPM_RT_SPLIT 2
`define SFPM_RT_LOAD 3
`define SFPM_RT_WARN 4
`define SFPM_RT_COMP_LSB 5
`define SFPM_RT_COMP_MSB 7

// Trim codes and the capacitance in pF that each selects.
`define SFPM_COMP_43 3'h0
`define SFPM_COMP_37 3'h1
`define SFPM_COMP_31 3'h2
`define SFPM_COMP_25 3'h3
`define SFPM_COMP_18 3'h4
`define SFPM_PF_43 6'h2b
`define SFPM_PF_37 6'h25
`define SFPM_PF_31 6'h1f
`define SFPM_PF_25 6'h19
`define SFPM_PF_18 6'h12
`define SFPM_PF_NONE 6'h00

// Positions in the vector of inputs that cross into the core clock.
`define SFPM_NPIN 18
`define SFPM_PIN_SCL 0
`define SFPM_PIN_SDA 1
`define SFPM_PIN_MUTE 2
`define SFPM_PIN_SHUT 3
`define SFPM_PIN_WARN 4
`define SFPM_PIN_HIGH 5
`define SFPM_PIN_LOW 6
`define SFPM_PIN_OC 7
`define SFPM_PIN_PUMP 8
`define SFPM_PIN_DIAG 9
`define SFPM_PIN_CLIP 10
`define SFPM_PIN_EXC 14

// Condition byte bit positions and idle levels of the synchronised pins.
`define SFPM_CD_SHUT 6
`define SFPM_CD_WARN 5
`define SFPM_CD_HIGH 4
`define SFPM_CD_LOW 3
`define SFPM_CD_OC 2
`define SFPM_PIN_IDLE 18'h03dff

// Bit counts of one bus byte.
`define SFPM_BITS_BYTE 4'h8
`define SFPM_BITS_ZERO 4'h0
`define SFPM_BITS_ONE 4'h1

`endif

// file: design/sfpm_pkg.sv
// Types shared by the status and fault-pin mapping block.
package sfpm_pkg;

  // Phases of the two-wire bus slave.
  typedef enum logic [3:0] {
    SFPM_IDLE,
    SFPM_ADDR,
    SFPM_ADDR_ACK,
    SFPM_PTR,
    SFPM_PTR_ACK,
    SFPM_WDATA,
    SFPM_WDATA_ACK,
    SFPM_RDATA,
    SFPM_RACK
  } sfpm_i2c_state_t;

  // Whole state of the core module.
  typedef struct packed {
    logic [17:0] meta;
    logic [17:0] sync;
    logic scl_d;
    logic sda_d;
    sfpm_i2c_state_t state;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic rw;
    logic mack;
    logic sda_oe_n;
    logic [7:0] routing;
    logic [3:0] load;
    logic [5:0] trim_pf;
    logic trim_rsvd;
  } sfpm_core_t;

  // Whole state of the pin mapper.
  typedef struct packed {
    logic alarm_oe_n;
    logic cl0_oe_n;
    logic cl1_oe_n;
    logic mute_req;
  } sfpm_map_t;

endpackage

// file: design/sfpm_top.sv
// Status register, indicator routing register and two-wire bus slave.
//
// Contract
// - Trim code selects 43/37/31/25/18 pF, rest reserved.
// - Warning drives alarm pin only with shutdown routing.
// - Load routing puts load indicators on clip pins.
// - Diagnostic current over threshold sets load indicator.
// - Split clear: one clip pin, shared pin mutes unless load routing is on.
// - Split set: clip pins cover outputs 0-1, 2-3.
// - Shutdown routing puts thermal shutdown on alarm pin.
// - Fault routing puts supply and overcurrent faults on pin.
// - Status byte layout: unused, shutdown ... clip summary.
// - Status flags read zero while their condition holds.
`timescale 1ns/10ps
`include "sfpm_params.svh"
module sfpm_top (
  // Clock and resets.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic soft_rst_in,
  // Two-wire control bus pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  // Raw condition flags from the analog monitors, active low.
  input wire logic thermal_shutdown_flag_n_in,
  input wire logic thermal_warning_flag_n_in,
  input wire logic supply_high_flag_n_in,
  input wire logic supply_low_flag_n_in,
  input wire logic overcurrent_summary_flag_n_in,
  input wire logic pump_hold_low_flag_n_in,
  input wire logic [3:0] clip_n_in,
  // Load diagnostic inputs.
  input wire logic diag_active_in,
  input wire logic [3:0] low_current_exceed_in,
  // Open-drain indicator pins.
  output logic combined_alarm_pin_n_out,
  output logic combined_alarm_pin_n_oe_n_out,
  output logic first_clipping_pin_n_out,
  output logic first_clipping_pin_n_oe_n_out,
  input wire logic silence_or_clipping_pin_n_in,
  output logic silence_or_clipping_pin_n_out,
  output logic silence_or_clipping_pin_n_oe_n_out,
  // Decoded controls for the analog core.
  output logic mute_request_out,
  output logic [2:0] comp_trim_out,
  output logic [5:0] trim_cap_pf_out,
  output logic trim_reserved_out,
  output logic [3:0] channel_load_out
);
  sfpm_pkg::sfpm_core_t q_ff, nxt_q;
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [`SFPM_NPIN-1:0] raw_pins;
  logic [7:0] condition;
  sfpm_map_if map_link ();

  // Capacitance selected by a trim code; reserved codes give none.
  function automatic logic [5:0] cap_pf(input logic [2:0] code);
    case (code)
      `SFPM_COMP_43: cap_pf = `SFPM_PF_43;
      `SFPM_COMP_37: cap_pf = `SFPM_PF_37;
      `SFPM_COMP_31: cap_pf = `SFPM_PF_31;
      `SFPM_COMP_25: cap_pf = `SFPM_PF_25;
      `SFPM_COMP_18: cap_pf = `SFPM_PF_18;
      default: cap_pf = `SFPM_PF_NONE;
    endcase
  endfunction

  // Register read decode; unmapped pointers read as zero.
  function automatic logic [7:0] reg_read(input logic [7:0] ptr,
                                          input logic [7:0] routing,
                                          input logic [7:0] cond);
    if (ptr == `SFPM_OFS_ROUTING) begin
      reg_read = routing;
    end else if (ptr == `SFPM_OFS_CONDITION) begin
      reg_read = cond;
    end else begin
      reg_read = `SFPM_READ_UNMAPPED;
    end
  endfunction

  // Reset release is synchronised so all flops leave reset together.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Every pin-side input passes two flops before any logic sees it.
  assign raw_pins = {low_current_exceed_in, clip_n_in, diag_active_in,
                     pump_hold_low_flag_n_in, overcurrent_summary_flag_n_in,
                     supply_low_flag_n_in, supply_high_flag_n_in,
                     thermal_warning_flag_n_in, thermal_shutdown_flag_n_in,
                     silence_or_clipping_pin_n_in, sda_in, scl_in};

  // Status byte, flags passed through with their active-low sense.
  assign condition = {1'b0,
                      q_ff.sync[`SFPM_PIN_SHUT],
                      q_ff.sync[`SFPM_PIN_WARN],
                      q_ff.sync[`SFPM_PIN_HIGH],
                      q_ff.sync[`SFPM_PIN_LOW],
                      q_ff.sync[`SFPM_PIN_OC],
                      q_ff.sync[`SFPM_PIN_PUMP],
                      &q_ff.sync[`SFPM_PIN_CLIP +: 4]};

  // Bus slave, load indicators and trim decode.
  always_comb begin
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic [7:0] rdata;
    nxt_q = q_ff;
    nxt_q.meta = raw_pins;
    nxt_q.sync = q_ff.meta;
    scl = q_ff.sync[`SFPM_PIN_SCL];
    sda = q_ff.sync[`SFPM_PIN_SDA];
    nxt_q.scl_d = scl;
    nxt_q.sda_d = sda;
    scl_rise = scl & ~q_ff.scl_d;
    scl_fall = ~scl & q_ff.scl_d;
    start = scl & q_ff.scl_d & q_ff.sda_d & ~sda;
    stop = scl & q_ff.scl_d & ~q_ff.sda_d & sda;
    rdata = reg_read(q_ff.ptr, q_ff.routing, condition);
    // Indicators follow the comparators only while a diagnostic runs.
    nxt_q.load = q_ff.sync[`SFPM_PIN_DIAG] ?
                 q_ff.sync[`SFPM_PIN_EXC +: 4] : 4'h0;
    nxt_q.trim_pf =
      cap_pf(q_ff.routing[`SFPM_RT_COMP_MSB:`SFPM_RT_COMP_LSB]);
    nxt_q.trim_rsvd = (nxt_q.trim_pf == `SFPM_PF_NONE);
    if (start) begin
      nxt_q.state = sfpm_pkg::SFPM_ADDR;
      nxt_q.bitcnt = `SFPM_BITS_ZERO;
      nxt_q.sda_oe_n = 1'b1;
    end else if (stop) begin
      nxt_q.state = sfpm_pkg::SFPM_IDLE;
      nxt_q.sda_oe_n = 1'b1;
    end else begin
      unique case (q_ff.state)
        sfpm_pkg::SFPM_IDLE: begin
          nxt_q.sda_oe_n = 1'b1;
        end
        sfpm_pkg::SFPM_ADDR, sfpm_pkg::SFPM_PTR, sfpm_pkg::SFPM_WDATA: begin
          if (scl_rise) begin
            nxt_q.shreg = {q_ff.shreg[6:0], sda};
            nxt_q.bitcnt = q_ff.bitcnt + `SFPM_BITS_ONE;
          end else if (scl_fall && q_ff.bitcnt == `SFPM_BITS_BYTE) begin
            nxt_q.sda_oe_n = 1'b0;
            if (q_ff.state == sfpm_pkg::SFPM_ADDR) begin
              nxt_q.rw = q_ff.shreg[0];
              if (q_ff.shreg[7:1] == `SFPM_DEV_ADDR) begin
                nxt_q.state = sfpm_pkg::SFPM_ADDR_ACK;
              end else begin
                nxt_q.state = sfpm_pkg::SFPM_IDLE;
                nxt_q.sda_oe_n = 1'b1;
              end
            end else if (q_ff.state == sfpm_pkg::SFPM_PTR) begin
              nxt_q.ptr = q_ff.shreg;
              nxt_q.state = sfpm_pkg::SFPM_PTR_ACK;
            end else begin
              // Only the routing register takes writes.
              if (q_ff.ptr == `SFPM_OFS_ROUTING) begin
                nxt_q.routing = q_ff.shreg;
              end
              nxt_q.ptr = q_ff.ptr + 8'h01;
              nxt_q.state = sfpm_pkg::SFPM_WDATA_ACK;
            end
          end
        end
        sfpm_pkg::SFPM_ADDR_ACK: begin
          if (scl_fall) begin
            nxt_q.bitcnt = `SFPM_BITS_ZERO;
            if (q_ff.rw) begin
              nxt_q.shreg = rdata;
              nxt_q.sda_oe_n = rdata[7];
              nxt_q.ptr = q_ff.ptr + 8'h01;
              nxt_q.state = sfpm_pkg::SFPM_RDATA;
            end else begin
              nxt_q.sda_oe_n = 1'b1;
              nxt_q.state = sfpm_pkg::SFPM_PTR;
            end
          end
        end
        sfpm_pkg::SFPM_PTR_ACK, sfpm_pkg::SFPM_WDATA_ACK: begin
          if (scl_fall) begin
            nxt_q.bitcnt = `SFPM_BITS_ZERO;
            nxt_q.sda_oe_n = 1'b1;
            nxt_q.state = sfpm_pkg::SFPM_WDATA;
          end
        end
        sfpm_pkg::SFPM_RDATA: begin
          if (scl_rise) begin
            nxt_q.bitcnt = q_ff.bitcnt + `SFPM_BITS_ONE;
          end else if (scl_fall) begin
            if (q_ff.bitcnt == `SFPM_BITS_BYTE) begin
              nxt_q.sda_oe_n = 1'b1;
              nxt_q.state = sfpm_pkg::SFPM_RACK;
            end else begin
              nxt_q.shreg = {q_ff.shreg[6:0], 1'b0};
              nxt_q.sda_oe_n = q_ff.shreg[6];
            end
          end
        end
        sfpm_pkg::SFPM_RACK: begin
          // A master NACK ends the read; the slave waits for stop.
          if (scl_rise) begin
            nxt_q.mack = ~sda;
          end else if (scl_fall) begin
            if (q_ff.mack) begin
              nxt_q.bitcnt = `SFPM_BITS_ZERO;
              nxt_q.shreg = rdata;
              nxt_q.sda_oe_n = rdata[7];
              nxt_q.ptr = q_ff.ptr + 8'h01;
              nxt_q.state = sfpm_pkg::SFPM_RDATA;
            end else begin
              nxt_q.state = sfpm_pkg::SFPM_IDLE;
            end
          end
        end
        default: begin
          nxt_q.state = sfpm_pkg::SFPM_IDLE;
          nxt_q.sda_oe_n = 1'b1;
        end
      endcase
    end
    // Soft reset returns the registers and the bus to their reset state.
    if (soft_rst_in) begin
      nxt_q.routing = `SFPM_ROUTING_POR;
      nxt_q.state = sfpm_pkg::SFPM_IDLE;
      nxt_q.sda_oe_n = 1'b1;
      nxt_q.ptr = 8'h00;
    end
  end

  // One register for the whole core state.
  always_ff @(posedge core_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q_ff <= '{meta: `SFPM_PIN_IDLE, sync: `SFPM_PIN_IDLE, scl_d: 1'b1,
                sda_d: 1'b1, state: sfpm_pkg::SFPM_IDLE, bitcnt: 4'h0,
                shreg: 8'h00, ptr: 8'h00, rw: 1'b0, mack: 1'b0,
                sda_oe_n: 1'b1, routing: `SFPM_ROUTING_POR, load: 4'h0,
                trim_pf: `SFPM_PF_31, trim_rsvd: 1'b0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  // Feed the pin mapper.
  assign map_link.routing = q_ff.routing;
  assign map_link.condition = condition;
  assign map_link.clip_n = q_ff.sync[`SFPM_PIN_CLIP +: 4];
  assign map_link.load = q_ff.load;
  assign map_link.mute_pin = q_ff.sync[`SFPM_PIN_MUTE];

  sfpm_map u_map (
    .clk_in(core_clk_in),
    .rst_n_in(rst_n),
    .m(map_link)
  );

  // Open-drain pins only ever pull low.
  assign sda_out = 1'b0;
  assign sda_oe_n_out = q_ff.sda_oe_n;
  assign combined_alarm_pin_n_out = 1'b0;
  assign combined_alarm_pin_n_oe_n_out = map_link.alarm_oe_n;
  assign first_clipping_pin_n_out = 1'b0;
  assign first_clipping_pin_n_oe_n_out = map_link.cl0_oe_n;
  assign silence_or_clipping_pin_n_out = 1'b0;
  assign silence_or_clipping_pin_n_oe_n_out = map_link.cl1_oe_n;
  assign mute_request_out = map_link.mute_req;
  assign comp_trim_out = q_ff.routing[`SFPM_RT_COMP_MSB:`SFPM_RT_COMP_LSB];
  assign trim_cap_pf_out = q_ff.trim_pf;
  assign trim_reserved_out = q_ff.trim_rsvd;
  assign channel_load_out = q_ff.load;
endmodule

// file: tb/sfpm_asserts.sv
// Port assertions for the status and fault-pin mapping block.
`timescale 1ns/10ps
module sfpm_asserts (
  // Clock and reset.
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  // Watched inputs.
  input wire logic thermal_shutdown_flag_n_in,
  input wire logic thermal_warning_flag_n_in,
  input wire logic supply_high_flag_n_in,
  input wire logic supply_low_flag_n_in,
  input wire logic overcurrent_summary_flag_n_in,
  input wire logic [3:0] clip_n_in,
  input wire logic diag_active_in,
  input wire logic [3:0] low_current_exceed_in,
  input wire logic silence_or_clipping_pin_n_in,
  // Watched outputs.
  input wire logic sda_out,
  input wire logic combined_alarm_pin_n_out,
  input wire logic combined_alarm_pin_n_oe_n_out,
  input wire logic first_clipping_pin_n_out,
  input wire logic first_clipping_pin_n_oe_n_out,
  input wire logic silence_or_clipping_pin_n_out,
  input wire logic silence_or_clipping_pin_n_oe_n_out,
  input wire logic mute_request_out,
  input wire logic [2:0] comp_trim_out,
  input wire logic [5:0] trim_cap_pf_out,
  input wire logic trim_reserved_out,
  input wire logic [3:0] channel_load_out
);
  logic [3:0] up_cnt_ff;
  logic up_ok;

  // Pins lag inputs through the reset and input synchronisers, so checks
  // that follow inputs wait until those have long settled.
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      up_cnt_ff <= 4'h0;
    end else if (up_cnt_ff != 4'hf) begin
      up_cnt_ff <= up_cnt_ff + 4'h1;
    end
  end
  assign up_ok = (up_cnt_ff == 4'hf);

  // Capacitance chosen by each trim code, zero for reserved codes.
  function automatic logic [5:0] pf_of(input logic [2:0] c);
    case (c)
      3'h0: return 6'h2b;
      3'h1: return 6'h25;
      3'h2: return 6'h1f;
      3'h3: return 6'h19;
      3'h4: return 6'h12;
      default: return 6'h00;
    endcase
  endfunction

  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  // Steady input situations that the pin outputs must have caught up with.
  sequence s_alarm_quiet;
    (up_ok && &{thermal_shutdown_flag_n_in, thermal_warning_flag_n_in,
      supply_high_flag_n_in, supply_low_flag_n_in,
      overcurrent_summary_flag_n_in})[*6];
  endsequence
  sequence s_clip_quiet;
    (up_ok && &clip_n_in && !(diag_active_in && |low_current_exceed_in))[*6];
  endsequence
  sequence s_load_steady;
    (up_ok && $stable({diag_active_in, low_current_exceed_in}))[*5];
  endsequence
  sequence s_pin_high;
    (up_ok && silence_or_clipping_pin_n_in)[*6];
  endsequence

  a_trim_cap_map: assert property ($stable(comp_trim_out) |->
    trim_cap_pf_out == pf_of(comp_trim_out)) else $error("trim pF wrong");
  a_trim_rsvd_flag: assert property ($stable(comp_trim_out) |->
    trim_reserved_out == (comp_trim_out > 3'h4)) else $error("reserved");
  a_load_follow: assert property (s_load_steady |->
    channel_load_out == ({4{diag_active_in}} & low_current_exceed_in))
    else $error("load indicators wrong");
  a_alarm_release: assert property (s_alarm_quiet |->
    combined_alarm_pin_n_oe_n_out) else $error("alarm pulled when quiet");
  a_clip_release: assert property (s_clip_quiet |->
    first_clipping_pin_n_oe_n_out && silence_or_clipping_pin_n_oe_n_out)
    else $error("clip pin pulled when quiet");
  a_mute_input_only: assert property (mute_request_out |->
    silence_or_clipping_pin_n_oe_n_out) else $error("mute while driving");
  a_mute_pin_high: assert property (s_pin_high |->
    !mute_request_out) else $error("mute with pin high");
  a_open_drain_zero: assert property (!(sda_out |
    combined_alarm_pin_n_out | first_clipping_pin_n_out |
    silence_or_clipping_pin_n_out)) else $error("open drain drives high");
endmodule

bind sfpm_top sfpm_asserts u_sfpm_asserts (.*);

// file: tb/sfpm_host_model.sv
// Two-wire bus host that reads and writes the block's registers.
`timescale 1ns/10ps
`include "sfpm_params.svh"
module sfpm_host (
  // Core clock, used only to start frames away from its rising edge.
  input wire logic clk_in,
  // Bus lines; the data line has a pull-up.
  output logic scl_out,
  output logic sda_drv_out,
  input wire logic sda_wire_in
);
  logic [7:0] acked;

  // The bus clock stands high and the data line released between frames.
  initial begin
    scl_out = 1'b1;
    sda_drv_out = 1'b1;
    acked = 8'h0;
  end

  // Start or repeated start, with 80 ns bus clock cycles from here on.
  task automatic start();
    @(negedge clk_in);
    #3 sda_drv_out = 1'b1;
    #30 scl_out = 1'b1;
    #40 sda_drv_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask
  task automatic stop();
    #20 sda_drv_out = 1'b0;
    #20 scl_out = 1'b1;
    #40 sda_drv_out = 1'b1;
  endtask
  task automatic put_bit(input logic b);
    #20 sda_drv_out = b;
    #20 scl_out = 1'b1;
    #40 scl_out = 1'b0;
  endtask
  // Sampled late in the high phase, well after the slave's output settles.
  task automatic get_bit(output logic b);
    #20 sda_drv_out = 1'b1;
    #20 scl_out = 1'b1;
    #30 b = sda_wire_in;
    #10 scl_out = 1'b0;
  endtask
  task automatic send(input logic [7:0] v);
    logic a;
    for (int i = 7; i >= 0; i--) begin
      put_bit(v[i]);
    end
    get_bit(a);
    acked = {7'h0, ~a};
  endtask
  task automatic write_reg(input logic [7:0] p, input logic [7:0] d);
    start();
    send({`SFPM_DEV_ADDR, 1'b0});
    send(p);
    send(d);
    stop();
  endtask
  // One byte from pointer p, ended by a not-acknowledge.
  task automatic read_reg(input logic [7:0] p, output logic [7:0] d);
    start();
    send({`SFPM_DEV_ADDR, 1'b0});
    send(p);
    start();
    send({`SFPM_DEV_ADDR, 1'b1});
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(1'b1);
    stop();
  endtask
endmodule

// file: tb/tb_status_fault_pin_mapping.sv
// Self-checking bench for the status and fault-pin mapping block.
`timescale 1ns/10ps
`include "sfpm_params.svh"
module tb_status_fault_pin_mapping;
  logic core_clk_in = 1'b0, rst_n_in = 1'b0, soft_rst_in = 1'b0;
  logic diag_active_in = 1'b0, mute_n = 1'b1;
  logic [3:0] clip_n_in = 4'hf, low_current_exceed_in = 4'h0;
  logic [5:0] flg = 6'h3f;
  wire scl_in, host_sda, sda_in, silence_or_clipping_pin_n_in;
  logic sda_out, sda_oe_n_out, combined_alarm_pin_n_out, mute_request_out;
  logic combined_alarm_pin_n_oe_n_out, first_clipping_pin_n_out;
  logic first_clipping_pin_n_oe_n_out, silence_or_clipping_pin_n_out;
  logic silence_or_clipping_pin_n_oe_n_out, trim_reserved_out;
  logic [2:0] comp_trim_out;
  logic [5:0] trim_cap_pf_out;
  logic [3:0] channel_load_out;
  logic [7:0] rt, rd;
  integer seed = 32'h29f0, miscompares = 0, num_checks = 0;

  // Open-drain lines with pull-ups: any party pulling low wins.
  assign sda_in = host_sda & (sda_oe_n_out | sda_out);
  assign silence_or_clipping_pin_n_in = mute_n &
    (silence_or_clipping_pin_n_oe_n_out | silence_or_clipping_pin_n_out);

  sfpm_top DUT (.*, .thermal_shutdown_flag_n_in(flg[5]),
    .thermal_warning_flag_n_in(flg[4]), .supply_high_flag_n_in(flg[3]),
    .supply_low_flag_n_in(flg[2]), .overcurrent_summary_flag_n_in(flg[1]),
    .pump_hold_low_flag_n_in(flg[0]));
  sfpm_host u_host (.clk_in(core_clk_in), .scl_out(scl_in),
    .sda_drv_out(host_sda), .sda_wire_in(sda_in));

  // Core clock at 100 MHz.
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end

  // Status byte: unused top bit, six flags, then the clip summary.
  function automatic logic [7:0] cond_exp();
    return {1'b0, flg, &clip_n_in};
  endfunction
  // Expected {mute, shared pin, first clip pin, alarm pin} for routing r.
  function automatic logic [7:0] pins_exp(input logic [7:0] r);
    logic al, c0, c1, l0, l1;
    l0 = r[3] & diag_active_in & |low_current_exceed_in[1:0];
    l1 = r[3] & diag_active_in & |low_current_exceed_in[3:2];
    al = (r[0] & ~&flg[3:1]) | (r[1] & ~flg[5]) | (r[1] & r[4] & ~flg[4]);
    c0 = (r[2] ? ~&clip_n_in[1:0] : ~&clip_n_in) | l0;
    c1 = (r[2] & ~&clip_n_in[3:2]) | l1;
    return {4'h0, ~(r[2] | r[3]) & ~mute_n, ~c1, ~c0, ~al};
  endfunction
  // Expected {reserved, 0, capacitance in pF} for a trim code.
  function automatic logic [7:0] trim_exp(input logic [2:0] t);
    logic [5:0] p;
    p = (t == 3'h0) ? 6'h2b : (t == 3'h1) ? 6'h25 : (t == 3'h2) ? 6'h1f :
      (t == 3'h3) ? 6'h19 : (t == 3'h4) ? 6'h12 : 6'h00;
    return {t > 3'h4, 1'b0, p};
  endfunction

  task automatic chk(input string nm, input logic [7:0] e,
    input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence: reset values, random routing and flags, refusals.
  initial begin
    repeat (20) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (5) @(negedge core_clk_in);
    u_host.read_reg(`SFPM_OFS_ROUTING, rd);
    chk("routing", 8'h40, rd);
    chk("trim", trim_exp(3'h2), {trim_reserved_out, 1'b0, trim_cap_pf_out});
    u_host.read_reg(`SFPM_OFS_CONDITION, rd);
    chk("condition", cond_exp(), rd);
    $display("test reset done");
    // Every trim code twice, reserved ones included on purpose.
    for (int i = 0; i < 16; i++) begin
      @(negedge core_clk_in);
      flg = 6'($random(seed) | $random(seed));
      clip_n_in = 4'($random(seed) | $random(seed));
      diag_active_in = 1'($random(seed));
      low_current_exceed_in = 4'($random(seed));
      mute_n = 1'($random(seed));
      rt = 8'($random(seed));
      rt[7:5] = i[2:0];
      rt[3] = diag_active_in;
      u_host.write_reg(`SFPM_OFS_ROUTING, rt);
      chk("ack", 8'h1, u_host.acked);
      u_host.read_reg(`SFPM_OFS_ROUTING, rd);
      chk("routing", rt, rd);
      u_host.read_reg(`SFPM_OFS_CONDITION, rd);
      chk("condition", cond_exp(), rd);
      chk("pins", pins_exp(rt),
        {4'h0, mute_request_out, silence_or_clipping_pin_n_oe_n_out,
        first_clipping_pin_n_oe_n_out,
        combined_alarm_pin_n_oe_n_out});
      chk("trim", trim_exp(i[2:0]),
        {trim_reserved_out, 1'b0, trim_cap_pf_out});
      chk("comp", {5'h0, i[2:0]}, {5'h0, comp_trim_out});
      chk("load", {4'h0, {4{diag_active_in}} &
        low_current_exceed_in}, {4'h0, channel_load_out});
    end
    $display("test routing done");
    // Smallest recommended trim, then the smaller one subwoofers allow.
    u_host.write_reg(`SFPM_OFS_ROUTING, 8'h20);
    chk("trim", trim_exp(3'h1),
      {trim_reserved_out, 1'b0, trim_cap_pf_out});
    u_host.write_reg(`SFPM_OFS_ROUTING, 8'h80);
    chk("trim", trim_exp(3'h4),
      {trim_reserved_out, 1'b0, trim_cap_pf_out});
    // The status byte ignores writes; unknown pointers read zero, unknown addresses refuse.
    u_host.write_reg(`SFPM_OFS_CONDITION, 8'h00);
    u_host.read_reg(`SFPM_OFS_CONDITION, rd);
    chk("condition", cond_exp(), rd);
    u_host.read_reg(8'h07, rd);
    chk("unmapped", 8'h00, rd);
    u_host.start();
    u_host.send(8'hd0);
    u_host.stop();
    chk("nack", 8'h0, u_host.acked);
    @(negedge core_clk_in);
    soft_rst_in = 1'b1;
    @(negedge core_clk_in);
    soft_rst_in = 1'b0;
    u_host.read_reg(`SFPM_OFS_ROUTING, rd);
    chk("routing", 8'h40, rd);
    $display("test refusals done");
    wrap_up();
  end

  // Cuts a hang short; the tests need about a fifth of this span.
  initial begin
    #800000;
    miscompares++;
    wrap_up();
  end
endmodule
